//--- hdl/ivr_pkg.sv
/*
 Constants and carrier types for the interrupt vector relocation block.
 Assumes a core that presents control register writes as a strobe with data.
*/
package ivr_pkg;
   // ---------------------------------------------------------------
   // Control register layout
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam int         SEL_BIT         = 1;
   localparam int         UNLOCK_BIT      = 0;
   localparam logic [7:0] CTRL_WR_MASK    = 8'h1F;
   localparam logic [7:0] CTRL_OWN_MASK   = 8'h03;
   // ---------------------------------------------------------------
   // Timing and addresses
   // ---------------------------------------------------------------
   localparam int         UNLOCK_CYCLES   = 4;
   localparam int         CNT_W           = 3;
   localparam int         PC_W            = 12;
   localparam logic [11:0] RESET_ADDR_APP  = 12'h000;
   localparam logic [11:0] VEC_FIRST       = 12'h001;
   localparam logic [11:0] VEC_LAST        = 12'h01F;
   localparam logic [11:0] BOOT_2K_START   = 12'hC00;
   localparam logic [11:0] BOOT_1K_START   = 12'hE00;
   localparam logic [11:0] BOOT_512_START  = 12'hF00;
   localparam logic [11:0] BOOT_256_START  = 12'hF80;

   typedef struct packed {
      logic        we;
      logic [7:0]  wdata;
   } ivr_wr_t;

   typedef struct packed {
      logic        boot_reset_fuse;      // 1 = programmed
      logic [1:0]  boot_size_fuses;
      logic        app_side_boot_lock;   // 1 = programmed
      logic        boot_side_boot_lock;  // 1 = programmed
   } ivr_fuse_t;

   typedef enum logic [0:0] {
      IVR_IDLE,
      IVR_OPEN
   } ivr_state_t;
endpackage

//--- hdl/ivr_unit.sv
/*
 Interrupt vector relocation: control register, timed unlock, masking,
 vector and reset address generation.
 Assumes register writes arrive as a one-cycle strobe, and fuses are static.
*/
// What this block does
// - Select bit zero: vectors fetched from the start of flash.
// - Select bit one: vectors fetched from boot section start, sized by fuses.
// - Unlock clears itself four cycles after set, or when select is written.
// - Interrupts masked from unlock set until after instruction following select write.
// - Without a select write, interrupts stay masked four cycles then release.
// - Automatic masking leaves the global interrupt enable bit untouched.
// - Boot vectors plus app-side lock: block interrupts while running application code.
// - App vectors plus boot-side lock: block interrupts while running boot code.
// - Boot reset fuse with 2K boot: reset at 0xC00, vectors at 0x001.
// - 2K boot with select set: vectors at 0xC01 through 0xC1F.
// - Control register resets to zero; bits 7..5 read-only; select bit1, unlock bit0.
// - Relocated vector address equals table address plus boot section start.
// - Reset address is 0x000 or boot start per fuse, independent of select.
`timescale 1ns/1ps
`default_nettype none
module ivr_unit
   import ivr_pkg::*;
#(
   parameter int UNLOCK_LEN = UNLOCK_CYCLES        // Cycles the unlock window stays open
)
(
   input  wire logic               clk,            // 50 MHz clock
   input  wire logic               srst,           // Sync reset, active high
   input  wire ivr_pkg::ivr_wr_t   ctrl_wr,        // Control register write
   output logic      [7:0]         ctrl_rdata,     // Control register read
   input  wire ivr_pkg::ivr_fuse_t fuses,          // Static fuse and lock bits
   input  wire logic               instr_done,     // Core retired an instruction
   input  wire logic [PC_W-1:0]    pc,             // Current fetch address
   input  wire logic               global_ie,      // Status register I bit
   input  wire logic [4:0]         vec_index,      // Vector number, 1..31
   output logic      [PC_W-1:0]    vec_addr,       // Vector fetch address
   output logic      [PC_W-1:0]    reset_addr,     // Reset entry address
   output logic                    irq_allow       // Interrupts may be taken
);
   import ivr_pkg::*;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // The countdown register must be able to hold the whole window
   if (UNLOCK_LEN < 1 || UNLOCK_LEN > (1 << CNT_W))
   begin : g_unlock_len_check
      $error("unlock window length not served by the countdown");
   end
   // The address must be wider than a vector number
   if (PC_W <= $bits(vec_index))
   begin : g_addr_width_check
      $error("fetch address narrower than the vector table");
   end
   // Boot section starts are kept at the width of the fetch address
   if (PC_W != $bits(BOOT_2K_START))
   begin : g_boot_width_check
      $error("boot start width differs from fetch address");
   end

   // ---------------------------------------------------------------
   // Control register and unlock window
   // ---------------------------------------------------------------
   logic [7:0]       ctrl;
   logic [7:0]       next_ctrl;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   ivr_state_t       state;
   ivr_state_t       next_state;
   logic             sel_taken;

   // Merges a write into the register, keeping or taking the select bit
   function automatic logic [7:0] merge_write(input logic [7:0] cur,
                                              input logic [7:0] wdata,
                                              input logic       take_sel);
      merge_write = (cur & ~CTRL_WR_MASK) | (wdata & CTRL_WR_MASK);
      if (!take_sel)
      begin
         merge_write[SEL_BIT] = cur[SEL_BIT];
      end
      merge_write = merge_write & (CTRL_OWN_MASK | CTRL_WR_MASK);
   endfunction

   // Vector number as an offset into a table
   function automatic logic [PC_W-1:0] vector_offset(input logic [4:0] idx);
      vector_offset = PC_W'(idx);
   endfunction

   function automatic logic [PC_W-1:0] boot_start(input logic [1:0] sz);
      case (sz)
         2'h0:    boot_start = BOOT_2K_START;
         2'h1:    boot_start = BOOT_1K_START;
         2'h2:    boot_start = BOOT_512_START;
         default: boot_start = BOOT_256_START;
      endcase
   endfunction

   always_comb
   begin
      next_ctrl  = ctrl;
      next_cnt   = cnt;
      next_state = state;
      sel_taken  = 1'b0;
      case (state)
         IVR_IDLE:
         begin
            if (ctrl_wr.we)
            begin
               next_ctrl = merge_write(ctrl, ctrl_wr.wdata, 1'b0);
               if (ctrl_wr.wdata[UNLOCK_BIT])
               begin
                  next_state = IVR_OPEN;
                  next_cnt   = CNT_W'(UNLOCK_LEN - 1);
               end
            end
         end
         IVR_OPEN:
         begin
            if (ctrl_wr.we && !ctrl_wr.wdata[UNLOCK_BIT])
            begin
               next_ctrl  = merge_write(ctrl, ctrl_wr.wdata, 1'b1);
               next_state = IVR_IDLE;
               sel_taken  = 1'b1;
            end
            else
            begin
               if (ctrl_wr.we)
               begin
                  // Unlock rewritten while open: other bits only, countdown goes on
                  next_ctrl = merge_write(ctrl, ctrl_wr.wdata, 1'b0);
               end
               if (cnt == '0)
               begin
                  next_ctrl[UNLOCK_BIT] = 1'b0;
                  next_state = IVR_IDLE;
               end
               else
               begin
                  next_cnt = cnt - CNT_W'(1);
               end
            end
         end
         default:
         begin
            next_state = IVR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl  <= CTRL_RESET;
         cnt   <= '0;
         state <= IVR_IDLE;
      end
      else
      begin
         ctrl  <= next_ctrl;
         cnt   <= next_cnt;
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Mask held after a select write
   // ---------------------------------------------------------------
   // Lets the instruction after the move retire before an interrupt is taken
   logic hold;
   logic next_hold;

   always_comb
   begin
      next_hold = hold;
      if (sel_taken)
      begin
         next_hold = 1'b1;
      end
      else if (instr_done)
      begin
         next_hold = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         hold <= 1'b0;
      end
      else
      begin
         hold <= next_hold;
      end
   end

   // ---------------------------------------------------------------
   // Boot section placement
   // ---------------------------------------------------------------
   logic [PC_W-1:0] bstart;
   logic            in_boot;

   always_comb
   begin
      bstart  = boot_start(fuses.boot_size_fuses);
      // Code at or above the boot start runs from the boot section
      in_boot = (pc >= bstart);
   end

   // ---------------------------------------------------------------
   // Vector fetch address
   // ---------------------------------------------------------------
   // Vector zero is the reset entry; numbers 1..31 follow it
   logic [PC_W-1:0] vec_q;
   logic [PC_W-1:0] next_vec_addr;

   always_comb
   begin
      if (ctrl[SEL_BIT])
      begin
         next_vec_addr = bstart + vector_offset(vec_index);
      end
      else
      begin
         next_vec_addr = vector_offset(vec_index);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         vec_q <= VEC_FIRST;
      end
      else
      begin
         vec_q <= next_vec_addr;
      end
   end

   // ---------------------------------------------------------------
   // Reset entry address
   // ---------------------------------------------------------------
   // Follows the fuse only; the select bit never moves the reset entry
   logic [PC_W-1:0] rst_q;
   logic [PC_W-1:0] next_reset_addr;

   always_comb
   begin
      if (fuses.boot_reset_fuse)
      begin
         next_reset_addr = bstart;
      end
      else
      begin
         next_reset_addr = RESET_ADDR_APP;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rst_q <= RESET_ADDR_APP;
      end
      else
      begin
         rst_q <= next_reset_addr;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt gating
   // ---------------------------------------------------------------
   // Each lock masks the section that does not hold the vectors
   logic app_block;
   logic boot_block;
   logic lock_block;

   always_comb
   begin
      app_block  = ctrl[SEL_BIT] && fuses.app_side_boot_lock && !in_boot;
      boot_block = !ctrl[SEL_BIT] && fuses.boot_side_boot_lock && in_boot;
      lock_block = app_block || boot_block;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign vec_addr   = vec_q;
   assign reset_addr = rst_q;
   assign ctrl_rdata = ctrl;
   // Mask is applied beside the I bit, never written into it
   assign irq_allow  = global_ie && (state == IVR_IDLE) && !hold && !lock_block;
endmodule
`default_nettype wire

//--- verif/ivr_monitor.sv
/* Checker for ivr_unit: register bits, unlock window, masking, addresses.
 Sees only the ports of ivr_unit and is bound to every instance. */
`timescale 1ns/1ps
`default_nettype none
module ivr_monitor
   import ivr_pkg::*;
(
   input  wire logic              clk,        // Clock
   input  wire logic              srst,       // Reset
   input  wire ivr_pkg::ivr_wr_t   ctrl_wr,    // Write
   input  wire logic [7:0]        ctrl_rdata, // Register
   input  wire ivr_pkg::ivr_fuse_t fuses,      // Fuses
   input  wire logic              instr_done, // Retire
   input  wire logic [11:0]       pc,         // Fetch
   input  wire logic              global_ie,  // I bit
   input  wire logic [4:0]        vec_index,  // Vector
   input  wire logic [11:0]       vec_addr,   // Vector address
   input  wire logic [11:0]       reset_addr, // Reset entry
   input  wire logic              irq_allow   // Allow
);
   logic [1:0]  bsz;
   logic [11:0] boot;
   logic        sel;
   logic        sel_wr;
   assign bsz = fuses.boot_size_fuses;
   assign boot = bsz == 2'h0 ? BOOT_2K_START : bsz == 2'h1 ? BOOT_1K_START :
                 bsz == 2'h2 ? BOOT_512_START : BOOT_256_START;
   assign sel = ctrl_rdata[1];
   assign sel_wr = ctrl_rdata[0] && ctrl_wr.we && !ctrl_wr.wdata[0];
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   ro_bits_a: assert property (ctrl_rdata[7:5] == 3'h0)
      else $error("read-only control bits not zero");
   unlock_clear_a: assert property ($rose(ctrl_rdata[0]) |-> ##4 !ctrl_rdata[0])
      else $error("unlock bit not cleared after four cycles");
   unlock_mask_a: assert property (ctrl_rdata[0] |-> !irq_allow)
      else $error("interrupts allowed while unlocked");
   sel_write_a: assert property (sel_wr |=> sel == $past(ctrl_wr.wdata[1]) && !ctrl_rdata[0])
      else $error("select write in window not taken");
   sel_refuse_a: assert property (!ctrl_rdata[0] && ctrl_wr.we |=> sel == $past(sel))
      else $error("select changed outside window");
   hold_mask_a: assert property (sel_wr |=> !irq_allow)
      else $error("interrupts allowed right after select write");
   release_a: assert property ($fell(ctrl_rdata[0]) && !$past(ctrl_wr.we) && global_ie
      && !fuses.app_side_boot_lock && !fuses.boot_side_boot_lock |-> irq_allow)
      else $error("mask not released after timeout");
   vec_addr_a: assert property (!$past(srst) && $stable(vec_index) && $stable(sel)
      |-> vec_addr == {7'h00, vec_index} + (sel ? boot : 12'h000))
      else $error("vector address wrong");
   reset_addr_a: assert property (!$past(srst)
      |-> reset_addr == (fuses.boot_reset_fuse ? boot : RESET_ADDR_APP))
      else $error("reset address wrong");
   app_lock_a: assert property (fuses.app_side_boot_lock && sel && pc < boot |-> !irq_allow)
      else $error("interrupt allowed in application code");
   boot_lock_a: assert property (fuses.boot_side_boot_lock && !sel && pc >= boot |-> !irq_allow)
      else $error("interrupt allowed in boot code");
endmodule
bind ivr_unit ivr_monitor i_ivr_monitor (.clk(clk), .srst(srst), .ctrl_wr(ctrl_wr), .ctrl_rdata(ctrl_rdata),
   .fuses(fuses), .instr_done(instr_done), .pc(pc), .global_ie(global_ie), .vec_index(vec_index),
   .vec_addr(vec_addr), .reset_addr(reset_addr), .irq_allow(irq_allow));
`default_nettype wire

//--- verif/tb_ivr_unit.sv
/* Bench for ivr_unit: reset values, vector move, refusal, timeout, locks.
 Drives every port itself at rising clock edges, except vec_index, held at 5'h1F throughout. */
`timescale 1ns/1ps
`default_nettype none
module tb_ivr_unit;
   import ivr_pkg::*;
   logic clk = 1'b0, srst = 1'b1, instr_done = 1'b0, global_ie = 1'b1, irq_allow;
   ivr_wr_t     ctrl_wr = '0;
   ivr_fuse_t   fuses = '0;
   logic [7:0]  ctrl_rdata;
   logic [11:0] pc = 12'h000, vec_addr, reset_addr;
   logic [4:0]  vec_index = 5'h1F;
   int          fail_count = 0, checked = 0, cycles = 0;
   ivr_unit i_ivr_unit (.clk(clk), .srst(srst), .ctrl_wr(ctrl_wr), .ctrl_rdata(ctrl_rdata),
      .fuses(fuses), .instr_done(instr_done), .pc(pc), .global_ie(global_ie), .vec_index(vec_index),
      .vec_addr(vec_addr), .reset_addr(reset_addr), .irq_allow(irq_allow));
   initial forever #10 clk = ~clk;
   task automatic end_of_test();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge clk) ctrl_wr <= '{we: 1'b1, wdata: d};
      @(posedge clk) ctrl_wr.we <= 1'b0;
      #1;
   endtask
   task automatic rst(input logic [4:0] f);
      @(posedge clk) srst <= 1'b1;
      fuses <= f;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // Unlock, select write, then one retired instruction
   task automatic mv(input logic [7:0] d);
      wr(8'h01);
      chk(12'(irq_allow), 12'h000);
      wr(d);
      chk(12'(ctrl_rdata), 12'(d));
      chk(12'(irq_allow), 12'h000);
      @(posedge clk) instr_done <= 1'b1;
      @(posedge clk) instr_done <= 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic s_move();
      mv(8'h02);
      chk(12'(irq_allow), 12'h001);
      chk(vec_addr, 12'hC1F);
      wr(8'hE0);
      chk(12'(ctrl_rdata), 12'h002);
      wr(8'h1C);
      chk(12'(ctrl_rdata), 12'h01E);
      wr(8'h00);
      chk(12'(ctrl_rdata), 12'h002);
   endtask
   task automatic s_timeout();
      wr(8'h01);
      repeat (3) @(posedge clk);
      #1 chk(12'(ctrl_rdata), 12'h003);
      chk(12'(irq_allow), 12'h000);
      @(posedge clk) #1 chk(12'(ctrl_rdata), 12'h002);
      chk(12'(irq_allow), 12'h001);
      mv(8'h00);
      chk(12'(ctrl_rdata), 12'h000);
      chk(vec_addr, 12'h01F);
      chk(12'(irq_allow), 12'h001);
      @(posedge clk) global_ie <= 1'b0;
      #1 chk(12'(irq_allow), 12'h000);
      @(posedge clk) global_ie <= 1'b1;
      #1 chk(12'(irq_allow), 12'h001);
   endtask
   task automatic s_locks();
      rst(5'b1_01_10);
      chk(reset_addr, BOOT_1K_START);
      mv(8'h02);
      chk(vec_addr, 12'hE1F);
      @(posedge clk) pc <= 12'h100;
      #1 chk(12'(irq_allow), 12'h000);
      @(posedge clk) pc <= 12'hE10;
      #1 chk(12'(irq_allow), 12'h001);
      rst(5'b1_00_01);
      chk(reset_addr, BOOT_2K_START);
      chk(vec_addr, 12'h01F);
      chk(12'(irq_allow), 12'h000);
      @(posedge clk) pc <= 12'h010;
      #1 chk(12'(irq_allow), 12'h001);
   endtask
   initial
   begin
      rst(5'b0_00_00);
      chk(12'(ctrl_rdata), 12'h000);
      chk(reset_addr, RESET_ADDR_APP);
      s_move();
      s_timeout();
      s_locks();
      end_of_test();
   end
endmodule
`default_nettype wire
